// file: ulc_pkg.sv
// Package for the USB link configuration register (lower portion).
// Assumes a 32-bit classic Wishbone slave and a 50 MHz controller clock.
`default_nettype none
package ulc_pkg;
  // Byte address of the register; byte address of the timeout readback word
  localparam logic [7:0] CFG_ONE_ADDR = 8'h84;
  localparam logic [7:0] SPEED_ADDR = 8'h8C;
  // Field positions
  localparam int U1_INIT_BIT = 10;
  localparam int U1_ACC_BIT = 9;
  localparam int LTM_BIT = 8;
  localparam int FS_LSB = 4;
  localparam int HS_LSB = 13;
  localparam int TRIM_W = 3;
  // Fallback defaults when no stored image exists
  localparam logic FB_U1_INIT = 1'b0;
  localparam logic FB_U1_ACC = 1'b1;
  localparam logic FB_LTM = 1'b0;
  localparam logic [2:0] FB_TRIM = 3'h0;
  // Timeout figures in tenths of a bit time
  localparam int TENTHS_W = 12;
  localparam logic [11:0] FS_BASE_TENTHS = 12'h0A0;
  localparam logic [11:0] FS_BASE_MIN = 12'h0A0;
  localparam logic [11:0] FS_BASE_MAX = 12'h0B4;
  localparam logic [11:0] FS_PER_CLK_TENTHS = 12'h002;
  // Wider than the 12-bit result; the sum is cut to 12 bits on purpose
  localparam logic [15:0] HS_BASE_TENTHS = 16'h1CC0;
  localparam logic [11:0] HS_PER_CLK_TENTHS = 12'h050;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] BAD_ADDR_WORD = 32'h0000_0000;
  // Speed codes
  typedef enum logic [1:0] {ULC_SPD_FS, ULC_SPD_HS, ULC_SPD_SS} ulc_speed_e;
endpackage : ulc_pkg
`default_nettype wire

// file: ulc_timeout_calc.sv
// Inter-packet timeout calculator: base plus trim times per-clock factor.
// Assumes the trim and speed inputs are registered by the caller.
`default_nettype none
module ulc_timeout_calc (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Trim values and speed
  input wire logic [2:0] fs_trim_i,
  input wire logic [2:0] hs_trim_i,
  input wire logic full_speed_i,
  // Results: selected trim, and timeout in tenths of a bit time
  output logic [2:0] trim_sel_o,
  output logic [11:0] timeout_tenths_o
);
  logic [2:0] nxt_sel;
  logic [11:0] nxt_tout;
  logic [2:0] sel_ff;
  logic [11:0] tout_ff;

  always_comb begin
    if (full_speed_i) begin
      nxt_sel = fs_trim_i;
      nxt_tout = ulc_pkg::FS_BASE_TENTHS +
        12'(fs_trim_i) * ulc_pkg::FS_PER_CLK_TENTHS;
    end else begin
      nxt_sel = hs_trim_i;
      nxt_tout = 12'(ulc_pkg::HS_BASE_TENTHS +
        12'(hs_trim_i) * ulc_pkg::HS_PER_CLK_TENTHS);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_ff <= ulc_pkg::FB_TRIM;
      tout_ff <= ulc_pkg::FS_BASE_TENTHS;
    end else begin
      sel_ff <= nxt_sel;
      tout_ff <= nxt_tout;
    end
  end

  assign trim_sel_o = sel_ff;
  assign timeout_tenths_o = tout_ff;

  chk_fs_sum: assert property (@(posedge clk_i) disable iff (rst_i)
    full_speed_i |=> tout_ff == ulc_pkg::FS_BASE_TENTHS +
      12'($past(fs_trim_i)) * ulc_pkg::FS_PER_CLK_TENTHS)
    else $error("fs timeout sum wrong");
  chk_hs_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    !full_speed_i |=> sel_ff == $past(hs_trim_i))
    else $error("hs trim not presented");
endmodule : ulc_timeout_calc
`default_nettype wire

// file: ulc_config_one.sv
// USB link configuration register one, lower portion, on classic Wishbone.
// Assumes the stored image arrives on img_* with img_valid_i per load.
//
// Overview of operation
// - Self-initiate U1 only when enable bit and host set-feature both set.
// - Accept host U1 requests when acceptance bit set, regardless of others.
// - Initiation bit ignores acceptance bit; all combinations valid.
// - LTM enabled exactly while bit 8 set.
// - Bits 10..8 survive resets covered by reset protection.
// - FS trim times per-clock factor is added to FS timeout.
// - Base FS timeout lies within 16 to 18 bit times.
// - Each 60 MHz trim clock adds 0.2 FS bit times.
// - Off full speed, present HS trim to the controller.
// - Initiation and LTM default to image else zero; reload on resets.
// - Acceptance defaults to image else one; reload on resets.
// - FS trim defaults to image else zero; reload on resets.
// - Each 60 MHz HS trim clock adds 8 HS bit times.
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`default_nettype none
module ulc_config_one (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Link resets and reset protection
  input wire logic usb_reset_i,
  input wire logic lite_reset_i,
  input wire logic reset_protect_i,
  // Stored configuration image
  input wire logic img_valid_i,
  input wire logic img_u1_init_i,
  input wire logic img_u1_acc_i,
  input wire logic img_ltm_i,
  input wire logic [2:0] img_fs_trim_i,
  input wire logic [2:0] img_hs_trim_i,
  // Link status
  input wire logic [1:0] speed_i,
  input wire logic host_u1_feature_i,
  input wire logic host_u1_req_i,
  input wire logic dev_u1_want_i,
  // Controller outputs
  output logic u1_initiate_o,
  output logic u1_accept_o,
  output logic latency_tolerance_msg_on_o,
  output logic [2:0] timeout_trim_o,
  output logic [11:0] timeout_tenths_o
);
  logic u1_self_initiate_allow_ff, nxt_u1_self_initiate_allow;
  logic u1_host_request_accept_ff, nxt_u1_host_request_accept;
  logic latency_tolerance_msg_on_ff, nxt_latency_tolerance_msg_on;
  logic [2:0] full_speed_timeout_trim_ff, nxt_full_speed_timeout_trim;
  logic [2:0] high_speed_timeout_trim_ff, nxt_high_speed_timeout_trim;
  // Last loaded image, so that link resets can restore it
  logic img_u1_init_ff, nxt_img_u1_init;
  logic img_u1_acc_ff, nxt_img_u1_acc;
  logic img_ltm_ff, nxt_img_ltm;
  logic [2:0] img_fs_ff, nxt_img_fs;
  logic [2:0] img_hs_ff, nxt_img_hs;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic ini_ff, nxt_ini;
  logic acc_ff, nxt_acc;
  logic link_rst;
  logic wr_cfg;
  logic req;
  logic full_speed;
  logic [31:0] cfg_word;

  assign req = cyc_i && stb_i && !ack_ff;
  assign wr_cfg = req && we_i && adr_i == ulc_pkg::CFG_ONE_ADDR;
  assign link_rst = usb_reset_i || lite_reset_i;
  assign full_speed = speed_i == 2'(ulc_pkg::ULC_SPD_FS);

  always_comb begin
    cfg_word = ulc_pkg::ZERO_WORD;
    cfg_word[ulc_pkg::U1_INIT_BIT] = u1_self_initiate_allow_ff;
    cfg_word[ulc_pkg::U1_ACC_BIT] = u1_host_request_accept_ff;
    cfg_word[ulc_pkg::LTM_BIT] = latency_tolerance_msg_on_ff;
    cfg_word[ulc_pkg::FS_LSB +: ulc_pkg::TRIM_W] = full_speed_timeout_trim_ff;
    cfg_word[ulc_pkg::HS_LSB +: ulc_pkg::TRIM_W] = high_speed_timeout_trim_ff;
  end

  // Image capture
  always_comb begin
    nxt_img_u1_init = img_u1_init_ff;
    nxt_img_u1_acc = img_u1_acc_ff;
    nxt_img_ltm = img_ltm_ff;
    nxt_img_fs = img_fs_ff;
    nxt_img_hs = img_hs_ff;
    if (img_valid_i) begin
      nxt_img_u1_init = img_u1_init_i;
      nxt_img_u1_acc = img_u1_acc_i;
      nxt_img_ltm = img_ltm_i;
      nxt_img_fs = img_fs_trim_i;
      nxt_img_hs = img_hs_trim_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      img_u1_init_ff <= ulc_pkg::FB_U1_INIT;
      img_u1_acc_ff <= ulc_pkg::FB_U1_ACC;
      img_ltm_ff <= ulc_pkg::FB_LTM;
      img_fs_ff <= ulc_pkg::FB_TRIM;
      img_hs_ff <= ulc_pkg::FB_TRIM;
    end else begin
      img_u1_init_ff <= nxt_img_u1_init;
      img_u1_acc_ff <= nxt_img_u1_acc;
      img_ltm_ff <= nxt_img_ltm;
      img_fs_ff <= nxt_img_fs;
      img_hs_ff <= nxt_img_hs;
    end
  end

  // Register fields; a link reset restores the image, a write by byte lane
  always_comb begin
    nxt_u1_self_initiate_allow = u1_self_initiate_allow_ff;
    nxt_u1_host_request_accept = u1_host_request_accept_ff;
    nxt_latency_tolerance_msg_on = latency_tolerance_msg_on_ff;
    nxt_full_speed_timeout_trim = full_speed_timeout_trim_ff;
    nxt_high_speed_timeout_trim = high_speed_timeout_trim_ff;
    if (img_valid_i || link_rst) begin
      // Protected bits keep their values across a covered reset
      if (!(link_rst && reset_protect_i) || img_valid_i) begin
        nxt_u1_self_initiate_allow = nxt_img_u1_init;
        nxt_u1_host_request_accept = nxt_img_u1_acc;
        nxt_latency_tolerance_msg_on = nxt_img_ltm;
      end
      nxt_full_speed_timeout_trim = nxt_img_fs;
      nxt_high_speed_timeout_trim = nxt_img_hs;
    end else if (wr_cfg) begin
      if (sel_i[1]) begin
        nxt_u1_self_initiate_allow = dat_i[ulc_pkg::U1_INIT_BIT];
        nxt_u1_host_request_accept = dat_i[ulc_pkg::U1_ACC_BIT];
        nxt_latency_tolerance_msg_on = dat_i[ulc_pkg::LTM_BIT];
        nxt_high_speed_timeout_trim =
          dat_i[ulc_pkg::HS_LSB +: ulc_pkg::TRIM_W];
      end
      if (sel_i[0]) begin
        nxt_full_speed_timeout_trim =
          dat_i[ulc_pkg::FS_LSB +: ulc_pkg::TRIM_W];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      u1_self_initiate_allow_ff <= ulc_pkg::FB_U1_INIT;
      u1_host_request_accept_ff <= ulc_pkg::FB_U1_ACC;
      latency_tolerance_msg_on_ff <= ulc_pkg::FB_LTM;
      full_speed_timeout_trim_ff <= ulc_pkg::FB_TRIM;
      high_speed_timeout_trim_ff <= ulc_pkg::FB_TRIM;
    end else begin
      u1_self_initiate_allow_ff <= nxt_u1_self_initiate_allow;
      u1_host_request_accept_ff <= nxt_u1_host_request_accept;
      latency_tolerance_msg_on_ff <= nxt_latency_tolerance_msg_on;
      full_speed_timeout_trim_ff <= nxt_full_speed_timeout_trim;
      high_speed_timeout_trim_ff <= nxt_high_speed_timeout_trim;
    end
  end

  // Bus answer: one wait state, unmapped reads return zero
  always_comb begin
    nxt_ack = req;
    nxt_dat = dat_ff;
    if (req && !we_i) begin
      if (adr_i == ulc_pkg::CFG_ONE_ADDR) begin
        nxt_dat = cfg_word;
      end else if (adr_i == ulc_pkg::SPEED_ADDR) begin
        nxt_dat = {20'h0_0000, timeout_tenths_o};
      end else begin
        nxt_dat = ulc_pkg::BAD_ADDR_WORD;
      end
    end
  end

  // Link-side power management outputs, registered
  always_comb begin
    nxt_ini = u1_self_initiate_allow_ff && host_u1_feature_i &&
      dev_u1_want_i;
    nxt_acc = u1_host_request_accept_ff && host_u1_req_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= ulc_pkg::ZERO_WORD;
      ini_ff <= 1'b0;
      acc_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      ini_ff <= nxt_ini;
      acc_ff <= nxt_acc;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;
  assign u1_initiate_o = ini_ff;
  assign u1_accept_o = acc_ff;
  assign latency_tolerance_msg_on_o = latency_tolerance_msg_on_ff;

  ulc_timeout_calc u_calc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fs_trim_i(full_speed_timeout_trim_ff),
    .hs_trim_i(high_speed_timeout_trim_ff),
    .full_speed_i(full_speed),
    .trim_sel_o(timeout_trim_o),
    .timeout_tenths_o(timeout_tenths_o)
  );

  chk_u1_init_gate: assert property (@(posedge clk_i)
    disable iff (rst_i)
    u1_initiate_o |-> $past(u1_self_initiate_allow_ff) &&
      $past(host_u1_feature_i))
    else $error("u1 initiated without both enables");
  chk_u1_accept: assert property (@(posedge clk_i)
    disable iff (rst_i)
    u1_host_request_accept_ff && host_u1_req_i |=> u1_accept_o)
    else $error("host u1 request not accepted");
  chk_indep: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr_cfg && sel_i[1] |=> u1_self_initiate_allow_ff ==
      $past(dat_i[ulc_pkg::U1_INIT_BIT]) || $past(link_rst)
      || $past(img_valid_i))
    else $error("init bit not independent");
  chk_ltm_out: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr_cfg && sel_i[1] && !link_rst && !img_valid_i |=>
      latency_tolerance_msg_on_o == $past(dat_i[ulc_pkg::LTM_BIT]))
    else $error("ltm output mismatch");
  chk_protect_hold: assert property (@(posedge clk_i)
    disable iff (rst_i)
    link_rst && reset_protect_i && !img_valid_i |=>
      $stable(u1_self_initiate_allow_ff) &&
      $stable(u1_host_request_accept_ff) &&
      $stable(latency_tolerance_msg_on_ff))
    else $error("protected bit changed on reset");
  chk_rsvd_zero: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ack_o && $past(adr_i) == ulc_pkg::CFG_ONE_ADDR && !$past(we_i)
      |-> dat_o[7] == 1'b0 && dat_o[3:2] == 2'b00)
    else $error("reserved bits read nonzero");
  chk_reload_bits: assert property (@(posedge clk_i)
    disable iff (rst_i)
    link_rst && !reset_protect_i && !img_valid_i |=>
      u1_self_initiate_allow_ff == img_u1_init_ff &&
      u1_host_request_accept_ff == img_u1_acc_ff &&
      latency_tolerance_msg_on_ff == img_ltm_ff)
    else $error("enable bits not restored");
  chk_reload_fs: assert property (@(posedge clk_i)
    disable iff (rst_i)
    link_rst && !img_valid_i |=> full_speed_timeout_trim_ff
      == img_fs_ff)
    else $error("fs trim not restored");
  chk_base_window: assert property (@(posedge clk_i)
    disable iff (rst_i)
    full_speed && full_speed_timeout_trim_ff == '0 |=>
      timeout_tenths_o >= ulc_pkg::FS_BASE_MIN &&
      timeout_tenths_o <= ulc_pkg::FS_BASE_MAX)
    else $error("fs base outside window");
  chk_trim_pick: assert property (@(posedge clk_i)
    disable iff (rst_i)
    full_speed |=> timeout_trim_o == $past(full_speed_timeout_trim_ff))
    else $error("fs trim not presented");
  chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
endmodule : ulc_config_one
`default_nettype wire

// file: ulc_host_port_model.sv
// Upstream host or hub port: speed, U1 feature and U1 request levels.
// Assumes commands from the bench; it re-times them onto its own edge.
`default_nettype none
module ulc_host_port_model (
  // Clock
  input wire logic clk_i,
  // Commands from the bench
  input wire logic [1:0] spd_cmd_i,
  input wire logic feat_cmd_i,
  input wire logic req_cmd_i,
  // Link status towards the device
  output logic [1:0] speed_o,
  output logic host_u1_feature_o,
  output logic host_u1_req_o
);
  // A real port changes speed or feature state only on its own clock
  always @(posedge clk_i) begin
    speed_o <= spd_cmd_i;
    host_u1_feature_o <= feat_cmd_i;
    host_u1_req_o <= req_cmd_i;
  end
endmodule // ulc_host_port_model
`default_nettype wire

// file: usb_u1_ltm_fs_timeout_cfg_tb_top.sv
// Self-checking bench for the link configuration register, lower part.
// Assumes the register answers one cycle after a classic Wishbone request.
`default_nettype none
module usb_u1_ltm_fs_timeout_cfg_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, dat_o, r;
  logic ack_o, usb = 1'b0, lite = 1'b0, prot = 1'b0, img_v = 1'b0;
  logic [2:0] img_fs = 3'h0, img_hs = 3'h0, trim_o;
  logic img_i = 1'b0, img_a = 1'b0, img_l = 1'b0, feat = 1'b0, req = 1'b0;
  logic want = 1'b0, u1_init_o, u1_acc_o, ltm_o, feat_l, req_l;
  logic [1:0] spd = 2'h0, spd_l;
  logic [3:0] sel = 4'hF;
  logic [11:0] tenths_o;
  int fails = 0, checked = 0;
  always #10 clk_i = ~clk_i;
  ulc_host_port_model i_host (.clk_i(clk_i), .spd_cmd_i(spd),
    .feat_cmd_i(feat), .req_cmd_i(req), .speed_o(spd_l),
    .host_u1_feature_o(feat_l), .host_u1_req_o(req_l));
  ulc_config_one i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .usb_reset_i(usb),
    .lite_reset_i(lite), .reset_protect_i(prot), .img_valid_i(img_v),
    .img_u1_init_i(img_i), .img_u1_acc_i(img_a), .img_ltm_i(img_l),
    .img_fs_trim_i(img_fs), .img_hs_trim_i(img_hs), .speed_i(spd_l),
    .host_u1_feature_i(feat_l), .host_u1_req_i(req_l),
    .dev_u1_want_i(want), .u1_initiate_o(u1_init_o),
    .u1_accept_o(u1_acc_o), .latency_tolerance_msg_on_o(ltm_o),
    .timeout_trim_o(trim_o), .timeout_tenths_o(tenths_o));
  task automatic conclude;
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Outputs lag the host model by two registers; four edges is ample
  // Returns at a rising edge; reads then see the values before that edge
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      fails++;
      conclude();
    end else begin
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  // Kind 0 bus reset, 1 lite reset, 2 image load
  task automatic lnk(input int k);
    @(posedge clk_i);
    usb <= (k == 0); lite <= (k == 1); img_v <= (k == 2);
    @(posedge clk_i);
    usb <= 1'b0; lite <= 1'b0; img_v <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    chk("tenths", 32'h0000_00A0, {20'h0, tenths_o});
    wb(1'b0, 8'h84, 32'h0, r);
    chk("cfg", 32'h0000_0200, r);
    wb(1'b1, 8'h84, 32'hFFFF_FFFF, r);
    wb(1'b0, 8'h84, 32'h0, r);
    chk("cfg", 32'h0000_E770, r);
    chk("ltm", 32'h1, {31'h0, ltm_o});
    feat <= 1'b1; req <= 1'b1; want <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h84, 32'(i) << 9, r);
      settle();
      chk("init", 32'(i >> 1), {31'h0, u1_init_o});
      chk("acc", 32'(i & 1), {31'h0, u1_acc_o});
      chk("ltm", 32'h0, {31'h0, ltm_o});
    end
    feat <= 1'b0;
    settle();
    chk("init", 32'h0, {31'h0, u1_init_o});
    wb(1'b1, 8'h84, 32'h0000_6050, r);
    settle();
    chk("trim", 32'h5, {29'h0, trim_o});
    chk("tenths", 32'h0000_00AA, {20'h0, tenths_o});
    for (int s = 1; s < 3; s++) begin
      spd <= 2'(s);
      settle();
      chk("trim", 32'h3, {29'h0, trim_o});
      chk("tenths", 32'h0000_0DB0, {20'h0, tenths_o});
    end
    spd <= 2'h0;
    settle();
    chk("trim", 32'h5, {29'h0, trim_o});
    wb(1'b1, 8'h84, 32'h0000_0550, r);
    prot <= 1'b1;
    lnk(0);
    wb(1'b0, 8'h84, 32'h0, r);
    chk("cfg", 32'h0000_0500, r);
    prot <= 1'b0;
    lnk(1);
    wb(1'b0, 8'h84, 32'h0, r);
    chk("cfg", 32'h0000_0200, r);
    img_i <= 1'b1; img_l <= 1'b1; img_fs <= 3'h6; img_hs <= 3'h2;
    lnk(2);
    wb(1'b1, 8'h84, 32'h0, r);
    lnk(0);
    wb(1'b0, 8'h84, 32'h0, r);
    chk("cfg", 32'h0000_4560, r);
    wb(1'b0, 8'h40, 32'h0, r);
    chk("unmapped", 32'h0, r);
    sel <= 4'h1;
    wb(1'b1, 8'h84, 32'hFFFF_FFFF, r);
    sel <= 4'hF;
    wb(1'b0, 8'h84, 32'h0, r);
    chk("cfg", 32'h0000_4570, r);
    wb(1'b0, 8'h8C, 32'h0, r);
    chk("tenths", 32'h0000_00AE, r);
    conclude();
  end
endmodule // usb_u1_ltm_fs_timeout_cfg_tb_top
`default_nettype wire
